// ---- core/sfa_pkg.sv ----
// shared constants and types for the status-flag and data-addressing slice
// assumes a single core clock; every user writes sfa_pkg::name, nothing is imported
`default_nettype none

package sfa_pkg;

    // ========================================================================
    // widths
    localparam int DW = 8;                 // data byte
    localparam int AW = 12;                // linear data address
    localparam int PCW = 20;               // program memory target
    localparam int BW = 4;                 // bank_pointer width
    localparam int NF = 5;                 // implemented flag bits
    localparam int NPTR = 3;               // file_pointer_pair count

    // ========================================================================
    // arith_flags bit positions
    localparam int FLAG_NEG = 4;           // result_below_flag
    localparam int FLAG_WRAP = 3;          // sign_wrap_flag
    localparam int FLAG_NIL = 2;           // result_nil_flag
    localparam int FLAG_HALF = 1;          // half_out_flag
    localparam int FLAG_HIGH = 0;          // high_out_flag

    // which flags each class of operation updates
    localparam logic [NF-1:0] UPD_NONE = 5'h00;
    localparam logic [NF-1:0] UPD_ALL = 5'h1f;
    localparam logic [NF-1:0] UPD_NZ = 5'h14;
    localparam logic [NF-1:0] UPD_ROT = 5'h17;

    // ========================================================================
    // special-function addresses
    localparam logic [AW-1:0] ADDR_STATUS = 12'hfd8;
    localparam logic [AW-1:0] ADDR_BANK = 12'hfe0;
    localparam logic [AW-1:0] ADDR_IND0 = 12'hfef;   // indirect_operand of pair 0
    localparam logic [AW-1:0] ADDR_PINC0 = 12'hfee;  // post_increment_operand of pair 0
    localparam logic [AW-1:0] ADDR_PHI0 = 12'hfea;   // pointer_high_byte of pair 0
    localparam logic [AW-1:0] ADDR_PLO0 = 12'hfe9;   // pointer_low_byte of pair 0
    localparam int PTR_STRIDE = 8;                   // pair n sits 8*n below pair 0

    // access bank split and indexed-literal-offset window
    localparam logic [DW-1:0] ACCESS_SPLIT = 8'h80;
    localparam logic [BW-1:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [DW-1:0] LIT_OFFSET_LIMIT = 8'h5f;
    localparam int LIT_OFFSET_PTR = 2;

    // ========================================================================
    // reset values and steps
    localparam logic [NF-1:0] FLAGS_RST = 5'h00;
    localparam logic [BW-1:0] BANK_RST = 4'h0;
    localparam logic [AW-1:0] PTR_RST = 12'h000;
    localparam logic [AW-1:0] PTR_INC = 12'h001;
    localparam logic [DW-1:0] ACC_RST = 8'h00;

    // ========================================================================
    // operations from the decoder
    typedef enum logic [3:0] {
        OP_NOP,
        OP_REG_ADD,
        OP_REG_SUB,
        OP_LIT_ADD,
        OP_LIT_SUB,
        OP_ROT_RIGHT,
        OP_ROT_LEFT,
        OP_AND,
        OP_OR,
        OP_XOR,
        OP_PASS,
        OP_STORE_ACC,
        OP_FULL_MOVE,
        OP_BRANCH
    } sfa_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_EXEC
    } sfa_state_t;

endpackage : sfa_pkg

`default_nettype wire

// ---- core/sfa_alu_flags.sv ----
// combinational arithmetic/logic unit with its status flag outputs
// assumes the caller registers results and merges flags under the update mask
`default_nettype none

module sfa_alu_flags (
    // operation and operands
    input wire sfa_pkg::sfa_op_t op,
    input wire logic [sfa_pkg::DW-1:0] acc,
    input wire logic [sfa_pkg::DW-1:0] opnd,
    input wire logic cin,
    // results
    output logic [sfa_pkg::DW-1:0] result,
    output logic [sfa_pkg::NF-1:0] flags,
    output logic [sfa_pkg::NF-1:0] upd
);

    // ========================================================================
    // adder
    logic sub;
    logic [7:0] x;
    logic [7:0] y;
    logic [8:0] sum;
    logic [4:0] half;

    // subtract is always operand minus accumulator, done as a complement add
    always_comb begin
        sub = (op == sfa_pkg::OP_REG_SUB) || (op == sfa_pkg::OP_LIT_SUB);
        x = sub ? opnd : acc;
        y = sub ? ~acc : acc ^ acc ^ opnd;
        sum = {1'b0, x} + {1'b0, y} + {8'h00, sub};
        half = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, sub};
        result = opnd;
        flags = sfa_pkg::FLAGS_RST;
        upd = sfa_pkg::UPD_NONE;
        unique case (op)
            sfa_pkg::OP_REG_ADD, sfa_pkg::OP_REG_SUB,
            sfa_pkg::OP_LIT_ADD, sfa_pkg::OP_LIT_SUB: begin
                result = sum[7:0];
                flags[sfa_pkg::FLAG_HALF] = half[4];
                flags[sfa_pkg::FLAG_HIGH] = sum[8];
                flags[sfa_pkg::FLAG_WRAP] = (x[7] == y[7]) && (sum[7] != x[7]);
                upd = sfa_pkg::UPD_ALL;
            end
            sfa_pkg::OP_ROT_RIGHT: begin
                result = {cin, opnd[7:1]};
                flags[sfa_pkg::FLAG_HIGH] = opnd[0];
                flags[sfa_pkg::FLAG_HALF] = opnd[4];
                upd = sfa_pkg::UPD_ROT;
            end
            sfa_pkg::OP_ROT_LEFT: begin
                result = {opnd[6:0], cin};
                flags[sfa_pkg::FLAG_HIGH] = opnd[7];
                flags[sfa_pkg::FLAG_HALF] = opnd[3];
                upd = sfa_pkg::UPD_ROT;
            end
            sfa_pkg::OP_AND: begin
                result = acc & opnd;
                upd = sfa_pkg::UPD_NZ;
            end
            sfa_pkg::OP_OR: begin
                result = acc | opnd;
                upd = sfa_pkg::UPD_NZ;
            end
            sfa_pkg::OP_XOR: begin
                result = acc ^ opnd;
                upd = sfa_pkg::UPD_NZ;
            end
            sfa_pkg::OP_PASS: begin
                upd = sfa_pkg::UPD_NZ;
            end
            default: begin
                result = opnd; // moves and stores leave flags alone
            end
        endcase
        flags[sfa_pkg::FLAG_NEG] = result[7];
        flags[sfa_pkg::FLAG_NIL] = (result == 8'h00);
    end

endmodule : sfa_alu_flags

`default_nettype wire

// ---- core/sfa_ptr_bank.sv ----
// the three 12-bit file_pointer_pair registers with byte writes and increment
// assumes write and increment requests come from logic on the same clock
`default_nettype none

module sfa_ptr_bank (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // byte write
    input wire logic wr_en,
    input wire logic [1:0] wr_idx,
    input wire logic wr_hi,
    input wire logic [sfa_pkg::DW-1:0] wr_data,
    // post increment, one bit per pair
    input wire logic [sfa_pkg::NPTR-1:0] inc_mask,
    // pointer values
    output logic [sfa_pkg::AW-1:0] ptr [sfa_pkg::NPTR]
);

    // ========================================================================
    // one pair per loop pass
    genvar g;
    generate
        for (g = 0; g < sfa_pkg::NPTR; g++) begin : g_pair
            logic [sfa_pkg::AW-1:0] ptr_ff;
            logic [sfa_pkg::AW-1:0] nxt_ptr;

            // a byte write wins over an increment: the written value stands
            always_comb begin
                nxt_ptr = ptr_ff;
                if (wr_en && (wr_idx == 2'(g))) begin
                    if (wr_hi) begin
                        nxt_ptr[11:8] = wr_data[3:0];
                    end else begin
                        nxt_ptr[7:0] = wr_data;
                    end
                end else if (inc_mask[g]) begin
                    nxt_ptr = ptr_ff + sfa_pkg::PTR_INC;
                end
            end

            // pair register
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    ptr_ff <= sfa_pkg::PTR_RST;
                end else if (ce) begin
                    ptr_ff <= nxt_ptr;
                end
            end

            assign ptr[g] = ptr_ff;
        end
    endgenerate

endmodule : sfa_ptr_bank

`default_nettype wire

// ---- core/sfa_core.sv ----
// status flags and data addressing slice of an 8-bit core
// assumes a decoder that presents one operation at a time and a data ram with
// one cycle of registered read latency; the config bit is static on this clock
`default_nettype none

module sfa_core (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // decoder request
    input wire logic op_valid,
    input wire sfa_pkg::sfa_op_t op_code,
    input wire logic [sfa_pkg::DW-1:0] op_file,
    input wire logic op_access,
    input wire logic op_dest,
    input wire logic [sfa_pkg::DW-1:0] op_lit,
    input wire logic [sfa_pkg::AW-1:0] op_src_full,
    input wire logic [sfa_pkg::AW-1:0] op_dst_full,
    input wire logic [sfa_pkg::PCW-1:0] op_target,
    input wire logic extended_set_enable,
    // data memory
    input wire logic [sfa_pkg::DW-1:0] mem_rdata,
    output logic [sfa_pkg::AW-1:0] mem_addr,
    output logic mem_re,
    output logic mem_we,
    output logic [sfa_pkg::DW-1:0] mem_wdata,
    // core state
    output logic busy,
    output logic done,
    output logic [sfa_pkg::DW-1:0] accum,
    output logic [sfa_pkg::DW-1:0] arith_flags,
    output logic [sfa_pkg::BW-1:0] bank_pointer,
    // program counter load
    output logic pc_load,
    output logic [sfa_pkg::PCW-1:0] pc_target
);

    // ========================================================================
    // address helpers

    // address of slot `base` for pair n
    function automatic logic [11:0] slot(input logic [11:0] base, input int n);
        return 12'(int'(base) - sfa_pkg::PTR_STRIDE * n);
    endfunction : slot

    // short file address to linear address
    function automatic logic [11:0] direct_addr(input logic [7:0] f, input logic a,
                                                input logic [3:0] bank, input logic ext,
                                                input logic [11:0] p2);
        if (a) begin
            return {bank, f};
        end else if (ext && (f <= sfa_pkg::LIT_OFFSET_LIMIT)) begin
            return p2 + {4'h0, f};
        end else if (f >= sfa_pkg::ACCESS_SPLIT) begin
            return {sfa_pkg::ACCESS_HIGH_BANK, f};
        end
        return {4'h0, f};
    endfunction : direct_addr

    // indirect_operand slots redirect to their pair, bank and access bit unused
    function automatic logic [11:0] resolve(input logic [11:0] raw,
                                            input logic [11:0] p [3]);
        logic [11:0] eff;
        eff = raw;
        for (int n = 0; n < sfa_pkg::NPTR; n++) begin
            if ((raw == slot(sfa_pkg::ADDR_IND0, n)) ||
                (raw == slot(sfa_pkg::ADDR_PINC0, n))) begin
                eff = p[n];
            end
        end
        return eff;
    endfunction : resolve

    // pairs that a post_increment_operand access must step
    function automatic logic [2:0] inc_of(input logic [11:0] raw);
        logic [2:0] m;
        m = 3'b000;
        for (int n = 0; n < sfa_pkg::NPTR; n++) begin
            m[n] = (raw == slot(sfa_pkg::ADDR_PINC0, n));
        end
        return m;
    endfunction : inc_of

    // virtual slots: nothing stored there
    function automatic logic is_virt(input logic [11:0] a);
        logic v;
        v = 1'b0;
        for (int n = 0; n < sfa_pkg::NPTR; n++) begin
            v |= (a == slot(sfa_pkg::ADDR_IND0, n)) || (a == slot(sfa_pkg::ADDR_PINC0, n));
        end
        return v;
    endfunction : is_virt

    function automatic logic is_lit(input sfa_pkg::sfa_op_t o);
        return (o == sfa_pkg::OP_LIT_ADD) || (o == sfa_pkg::OP_LIT_SUB);
    endfunction : is_lit

    // ========================================================================
    // state
    sfa_pkg::sfa_state_t state_ff, nxt_state;
    sfa_pkg::sfa_op_t op_ff, nxt_op;
    logic dest_ff, nxt_dest;
    logic [11:0] src_ff, nxt_src;
    logic [11:0] dst_ff, nxt_dst;
    logic [7:0] lit_ff, nxt_lit;
    logic [2:0] inc_ff, nxt_inc;
    logic [7:0] acc_ff, nxt_acc;
    logic [4:0] flags_ff, nxt_flags;
    logic [3:0] bank_ff, nxt_bank;
    logic [11:0] mem_addr_ff, nxt_mem_addr;
    logic mem_re_ff, nxt_mem_re;
    logic mem_we_ff, nxt_mem_we;
    logic [7:0] mem_wdata_ff, nxt_mem_wdata;
    logic busy_ff, nxt_busy;
    logic done_ff, nxt_done;
    logic pc_load_ff, nxt_pc_load;
    logic [19:0] pc_target_ff, nxt_pc_target;

    // datapath wires
    logic [11:0] ptr [3];
    logic [11:0] raw_src;
    logic [7:0] opnd;
    logic loc_hit;
    logic [7:0] loc_rd;
    logic [7:0] wval;
    logic to_acc;
    logic [4:0] fl_merge;
    logic [7:0] alu_res;
    logic [4:0] alu_fl;
    logic [4:0] alu_upd;
    logic pw_en;
    logic [1:0] pw_idx;
    logic pw_hi;
    logic [2:0] p_inc;

    // ========================================================================
    // submodules
    sfa_alu_flags u_alu (
        .op(op_ff),
        .acc(acc_ff),
        .opnd(opnd),
        .cin(flags_ff[sfa_pkg::FLAG_HIGH]),
        .result(alu_res),
        .flags(alu_fl),
        .upd(alu_upd)
    );

    sfa_ptr_bank u_ptr (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .wr_en(pw_en),
        .wr_idx(pw_idx),
        .wr_hi(pw_hi),
        .wr_data(wval),
        .inc_mask(p_inc),
        .ptr(ptr)
    );

    // ========================================================================
    // sequencer: take, wait for ram, execute and write back
    always_comb begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_dest = dest_ff;
        nxt_src = src_ff;
        nxt_dst = dst_ff;
        nxt_lit = lit_ff;
        nxt_inc = inc_ff;
        nxt_acc = acc_ff;
        nxt_flags = flags_ff;
        nxt_bank = bank_ff;
        nxt_mem_addr = mem_addr_ff;
        nxt_mem_re = 1'b0;
        nxt_mem_we = 1'b0;
        nxt_mem_wdata = mem_wdata_ff;
        nxt_done = 1'b0;
        nxt_pc_load = 1'b0;
        nxt_pc_target = pc_target_ff;
        raw_src = op_src_full;
        pw_en = 1'b0;
        pw_idx = 2'd0;
        pw_hi = 1'b0;
        p_inc = 3'b000;
        // status reads back with its upper three bits at zero
        loc_hit = 1'b0;
        loc_rd = 8'h00;
        if (src_ff == sfa_pkg::ADDR_STATUS) begin
            loc_hit = 1'b1;
            loc_rd = {3'b000, flags_ff};
        end else if (src_ff == sfa_pkg::ADDR_BANK) begin
            loc_hit = 1'b1;
            loc_rd = {4'h0, bank_ff};
        end
        for (int n = 0; n < sfa_pkg::NPTR; n++) begin
            if (src_ff == slot(sfa_pkg::ADDR_PHI0, n)) begin
                loc_hit = 1'b1;
                loc_rd = {4'h0, ptr[n][11:8]};
            end else if (src_ff == slot(sfa_pkg::ADDR_PLO0, n)) begin
                loc_hit = 1'b1;
                loc_rd = ptr[n][7:0];
            end
        end
        if (is_lit(op_ff)) begin
            opnd = lit_ff;
        end else if (loc_hit) begin
            opnd = loc_rd;
        end else if (is_virt(src_ff)) begin
            opnd = 8'h00;
        end else begin
            opnd = mem_rdata;
        end
        wval = (op_ff == sfa_pkg::OP_STORE_ACC) ? acc_ff : alu_res;
        to_acc = is_lit(op_ff) || (!dest_ff && (op_ff != sfa_pkg::OP_STORE_ACC) &&
                 (op_ff != sfa_pkg::OP_FULL_MOVE));
        fl_merge = (flags_ff & ~alu_upd) | (alu_fl & alu_upd);
        unique case (state_ff)
            sfa_pkg::ST_IDLE: begin
                if (op_valid && (op_code == sfa_pkg::OP_BRANCH)) begin
                    nxt_pc_target = op_target;
                    nxt_pc_load = 1'b1;
                    nxt_done = 1'b1;
                end else if (op_valid) begin
                    if (op_code != sfa_pkg::OP_FULL_MOVE) begin
                        raw_src = direct_addr(op_file, op_access, bank_ff, extended_set_enable,
                                              ptr[sfa_pkg::LIT_OFFSET_PTR]);
                    end
                    nxt_src = resolve(raw_src, ptr);
                    nxt_dst = nxt_src;
                    nxt_inc = inc_of(raw_src);
                    if (op_code == sfa_pkg::OP_FULL_MOVE) begin
                        nxt_dst = resolve(op_dst_full, ptr);
                        nxt_inc = nxt_inc | inc_of(op_dst_full);
                    end
                    nxt_op = op_code;
                    nxt_dest = op_dest;
                    nxt_lit = op_lit;
                    nxt_mem_addr = nxt_src;
                    nxt_mem_re = !is_lit(op_code) && !is_virt(nxt_src);
                    nxt_state = sfa_pkg::ST_WAIT;
                end
            end
            sfa_pkg::ST_WAIT: begin
                nxt_state = sfa_pkg::ST_EXEC; // ram data lands during the next cycle
            end
            sfa_pkg::ST_EXEC: begin
                nxt_flags = fl_merge;
                if (to_acc) begin
                    nxt_acc = alu_res;
                end else if (dst_ff == sfa_pkg::ADDR_STATUS) begin
                    if (alu_upd == sfa_pkg::UPD_NONE) begin
                        nxt_flags = wval[4:0];
                    end // else result dropped, flags only
                end else if (dst_ff == sfa_pkg::ADDR_BANK) begin
                    nxt_bank = wval[3:0];
                end else if (!is_virt(dst_ff)) begin
                    nxt_mem_addr = dst_ff;
                    nxt_mem_we = 1'b1;
                    nxt_mem_wdata = wval;
                    for (int n = 0; n < sfa_pkg::NPTR; n++) begin
                        if ((dst_ff == slot(sfa_pkg::ADDR_PHI0, n)) ||
                            (dst_ff == slot(sfa_pkg::ADDR_PLO0, n))) begin
                            pw_en = 1'b1;
                            pw_idx = 2'(n);
                            pw_hi = (dst_ff == slot(sfa_pkg::ADDR_PHI0, n));
                            nxt_mem_we = 1'b0; // pair bytes live here, not in ram
                        end
                    end
                end
                p_inc = inc_ff;
                nxt_done = 1'b1;
                nxt_state = sfa_pkg::ST_IDLE;
            end
        endcase
        nxt_busy = (nxt_state != sfa_pkg::ST_IDLE);
    end

    // registers; ce low freezes everything
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= sfa_pkg::ST_IDLE;
            op_ff <= sfa_pkg::OP_NOP;
            dest_ff <= 1'b0;
            src_ff <= sfa_pkg::PTR_RST;
            dst_ff <= sfa_pkg::PTR_RST;
            lit_ff <= sfa_pkg::ACC_RST;
            inc_ff <= 3'b000;
            acc_ff <= sfa_pkg::ACC_RST;
            flags_ff <= sfa_pkg::FLAGS_RST;
            bank_ff <= sfa_pkg::BANK_RST;
            mem_addr_ff <= sfa_pkg::PTR_RST;
            mem_re_ff <= 1'b0;
            mem_we_ff <= 1'b0;
            mem_wdata_ff <= sfa_pkg::ACC_RST;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            pc_load_ff <= 1'b0;
            pc_target_ff <= 20'h00000;
        end else if (ce) begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            dest_ff <= nxt_dest;
            src_ff <= nxt_src;
            dst_ff <= nxt_dst;
            lit_ff <= nxt_lit;
            inc_ff <= nxt_inc;
            acc_ff <= nxt_acc;
            flags_ff <= nxt_flags;
            bank_ff <= nxt_bank;
            mem_addr_ff <= nxt_mem_addr;
            mem_re_ff <= nxt_mem_re;
            mem_we_ff <= nxt_mem_we;
            mem_wdata_ff <= nxt_mem_wdata;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            pc_load_ff <= nxt_pc_load;
            pc_target_ff <= nxt_pc_target;
        end
    end

    // ========================================================================
    // outputs, all straight from flops
    assign mem_addr = mem_addr_ff;
    assign mem_re = mem_re_ff;
    assign mem_we = mem_we_ff;
    assign mem_wdata = mem_wdata_ff;
    assign busy = busy_ff;
    assign done = done_ff;
    assign accum = acc_ff;
    assign arith_flags = {3'b000, flags_ff};
    assign bank_pointer = bank_ff;
    assign pc_load = pc_load_ff;
    assign pc_target = pc_target_ff;

endmodule : sfa_core

`default_nettype wire

// ---- tb/sfa_core_asserts.sv ----
// checker for the status flag and addressing slice
// assumes ce held high by the bench, so result lands three edges after take
`default_nettype none

module sfa_core_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // decoder request and core outputs
    input wire logic ce, op_valid, op_access, busy, done, pc_load, mem_re,
    input wire sfa_pkg::sfa_op_t op_code,
    input wire logic [7:0] op_file, op_lit, accum, arith_flags,
    input wire logic [3:0] bank_pointer,
    input wire logic [11:0] mem_addr,
    input wire logic [19:0] op_target, pc_target
);
    timeunit 1ns;
    timeprecision 1ps;
    // ======
    // take detection and operand capture
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire tk = ce && op_valid && !busy;
    wire ad = tk && op_code == sfa_pkg::OP_LIT_ADD;
    wire sb = tk && op_code == sfa_pkg::OP_LIT_SUB;
    logic [7:0] a_ff, l_ff;
    // operands frozen at take; no new take can land before the result is judged
    always_ff @(posedge clk) begin
        if (tk) a_ff <= accum;
        if (tk) l_ff <= op_lit;
    end

    AST_UNUSED: assert property (arith_flags[7:5] == 3'h0)
        else $error("upper status bits not zero");
    AST_CARRY: assert property (ad |-> ##3 {arith_flags[0], accum} == {1'b0, a_ff} + l_ff)
        else $error("add result or carry wrong");
    AST_HALF: assert property (ad |-> ##3 arith_flags[1] == ({1'b0, a_ff[3:0]} + l_ff[3:0] > 5'h0f))
        else $error("half carry wrong");
    AST_NEGZ: assert property ((ad || sb) |-> ##3 arith_flags[4] == accum[7] && arith_flags[2] == (accum == 8'h00))
        else $error("sign or zero flag wrong");
    AST_SUB: assert property (sb |-> ##3 accum == l_ff - a_ff && arith_flags[0] == (l_ff >= a_ff))
        else $error("subtract or borrow wrong");
    AST_DONE: assert property (tk && op_code != sfa_pkg::OP_BRANCH |=> !done [*2] ##1 done)
        else $error("done not on third edge");
    AST_BR: assert property (tk && op_code == sfa_pkg::OP_BRANCH |=> pc_load && pc_target == $past(op_target))
        else $error("branch target wrong");
    AST_BANK: assert property (tk && op_access && op_code == sfa_pkg::OP_REG_ADD |=> mem_re && mem_addr == {bank_pointer, $past(op_file)})
        else $error("banked address wrong");
    cover property (ad);
    cover property (sb);
    cover property (pc_load);
endmodule : sfa_core_asserts

bind sfa_core sfa_core_asserts chk (.*);

`default_nettype wire

// ---- tb/sfa_ram_model.sv ----
// data ram with one registered read cycle, preloaded with address xor 5a
// assumes the core pulses mem_re and mem_we for one cycle each
`default_nettype none

module sfa_ram_model (
    // clock
    input wire logic clk,
    // core side
    input wire logic [11:0] mem_addr,
    input wire logic mem_re, mem_we,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [4096];
    // ======
    // preload and access
    initial begin
        mem_rdata = 8'h00;
        for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h5a;
    end
    // read data turns over when not read, so a late sample never sees a stale match
    always @(posedge clk) begin
        if (mem_we) mem[mem_addr] <= mem_wdata;
        mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
    end
endmodule : sfa_ram_model

`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench: literal, register, rotate, pointer and branch operations
// assumes ram model preload of address xor 5a
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, op_valid, op_access, op_dest, mem_re, mem_we, done;
    sfa_pkg::sfa_op_t op_code;
    logic [7:0] op_file, op_lit, mem_rdata, mem_wdata, accum, arith_flags, a;
    logic [11:0] mem_addr;
    logic [19:0] pc_target;
    logic [12:0] r;
    logic [7:0] lv [4] = '{8'h88, 8'h88, 8'h10, 8'h05};
    logic [7:0] pv [3] = '{8'h67, 8'h64, 8'h65};
    int fails, checked;
    logic ext = 1'b0;
    sfa_core uut (.ce(1'b1), .op_src_full(12'h000), .op_dst_full(12'h000),
        .op_target(20'habcde), .extended_set_enable(ext), .busy(), .bank_pointer(),
        .pc_load(), .*);
    sfa_ram_model ram (.*);

    // ======
    // reference flags {n, ov, z, dc, c} and result of x + y + c
    function automatic logic [12:0] ar(logic [7:0] x, y, logic c);
        logic [8:0] s;
        s = {1'b0, x} + y + c;
        return {s[7], x[7] == y[7] && s[7] != x[7], s[7:0] == 8'h00,
            {1'b0, x[3:0]} + y[3:0] + c > 5'h0f, s[8], s[7:0]};
    endfunction : ar

    task automatic chk(string nm, logic [23:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic stop_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test

    // one decoder request, then a bounded wait for done
    task automatic op(sfa_pkg::sfa_op_t c, logic [7:0] f, logic ac, d, logic [7:0] l);
        int n;
        @(negedge clk);
        op_code = c;
        op_file = f;
        op_access = ac;
        op_dest = d;
        op_lit = l;
        op_valid = 1'b1;
        @(negedge clk);
        op_valid = 1'b0;
        for (n = 0; n < 9 && done !== 1'b1; n++) @(negedge clk);
        if (n == 9) begin
            fails++;
            stop_test();
        end
    endtask : op

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        {rst, op_valid, op_access, op_dest, op_file, op_lit, a} = {4'h8, 24'h000000};
        op_code = sfa_pkg::OP_NOP;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        chk("reset", {arith_flags, accum}, 16'h0000);
        // two adds then two subtracts: sign, wrap, zero, half and carry cases
        for (int i = 0; i < 4; i++) begin
            r = i < 2 ? ar(a, lv[i], 1'b0) : ar(lv[i], ~a, 1'b1);
            op(i < 2 ? sfa_pkg::OP_LIT_ADD : sfa_pkg::OP_LIT_SUB, 8'h00, 1'b0, 1'b0, lv[i]);
            a = r[7:0];
            chk("lit", {arith_flags, accum}, {3'h0, r});
        end
        r = ar(a, 8'h7a, 1'b0);
        op(sfa_pkg::OP_REG_ADD, 8'h20, 1'b1, 1'b0, 8'h00);
        a = r[7:0];
        chk("reg", {arith_flags, accum}, {3'h0, r});
        r = ar(a, 8'h7a, 1'b0);
        op(sfa_pkg::OP_REG_ADD, 8'h20, 1'b0, 1'b1, 8'h00);
        // the ram takes the write one edge after done
        @(negedge clk);
        chk("back", {arith_flags, ram.mem[12'h020], accum}, {3'h0, r, a});
        op(sfa_pkg::OP_ROT_RIGHT, 8'h21, 1'b0, 1'b0, 8'h00);
        chk("rot", {arith_flags, accum}, 16'h0b3d);
        // pointer 0 low byte gets 3d, then post increment twice and plain indirect
        op(sfa_pkg::OP_STORE_ACC, 8'he9, 1'b0, 1'b1, 8'h00);
        for (int i = 0; i < 3; i++) begin
            op(sfa_pkg::OP_PASS, i < 2 ? 8'hee : 8'hef, 1'b0, 1'b0, 8'h00);
            chk("ind", accum, pv[i]);
        end
        // pointer 2 low byte gets 65, then offset 05 in extended mode reads 06a
        op(sfa_pkg::OP_STORE_ACC, 8'hd9, 1'b0, 1'b1, 8'h00);
        ext = 1'b1;
        op(sfa_pkg::OP_PASS, 8'h05, 1'b0, 1'b0, 8'h00);
        chk("ext", accum, 8'h30);
        op(sfa_pkg::OP_BRANCH, 8'h00, 1'b0, 1'b0, 8'h00);
        chk("pc", pc_target, 20'habcde);
        stop_test();
    end
endmodule : testbench

`default_nettype wire
